// ### rtl/acr_pkg.sv
package acr_pkg;
  // ==========================================================
  // bus and register map
  localparam int           ACR_AW        = 4;
  localparam int           ACR_DW        = 16;
  localparam int           ACR_NCH       = 4;
  localparam int           ACR_SW        = 24;
  localparam logic [3:0]   ADDR_CFG      = 4'h6;
  localparam logic [3:0]   ADDR_TH_HI    = 4'h7;
  localparam logic [3:0]   ADDR_TH_LO    = 4'h8;
  localparam logic [3:0]   ADDR_CHAN0_CONFIG  = 4'h9;
  localparam logic [3:0]   ADDR_OCAL_HI  = 4'hA;
  localparam logic [3:0]   ADDR_OCAL_LO  = 4'hB;
  localparam logic [3:0]   ADDR_GCAL_HI  = 4'hC;
  localparam logic [3:0]   ADDR_GCAL_LO  = 4'hD;
  localparam logic [3:0]   ADDR_IRQ_STAT = 4'hE;
  localparam logic [3:0]   ADDR_IRQ_MASK = 4'hF;
  // ==========================================================
  // reset values and writable-bit masks
  localparam logic [15:0]  RST_CFG       = 16'h0600;
  localparam logic [15:0]  RST_GCAL_HI   = 16'h8000;
  localparam logic [15:0]  RST_ZERO      = 16'h0000;
  localparam logic [15:0]  MASK_FULL     = 16'hFFFF;
  localparam logic [15:0]  MASK_TH_LO    = 16'hFF0F;
  localparam logic [15:0]  MASK_CH0      = 16'hFFC7;
  localparam logic [15:0]  MASK_LOW_BYTE = 16'hFF00;
  localparam logic [15:0]  MASK_IRQ      = 16'h0003;
  // ==========================================================
  // field positions
  localparam int           CFG_EN        = 0;
  localparam int           CFG_LEN_LSB   = 1;
  localparam int           CFG_LEN_MSB   = 3;
  localparam int           CFG_NUM_LSB   = 4;
  localparam int           CFG_NUM_MSB   = 6;
  localparam int           CFG_ALL       = 7;
  localparam int           DCB_MSB       = 3;
  localparam int           CH0_PH_LSB    = 6;
  localparam int           CH0_DIS       = 2;
  localparam int           CH0_MUX_MSB   = 1;
  localparam int           HI_BYTE_LSB   = 8;
  localparam int           IRQ_DETECT    = 0;
  localparam int           IRQ_WINDOW    = 1;
  localparam logic [3:0]   DCB_OFF       = 4'h0;
  // ==========================================================
  // detect engine types and lookups
  typedef enum logic [1:0] {
    ACR_IDLE = 2'b01,
    ACR_RUN  = 2'b10
  } acr_det_state_t;

  // measurement window in conversion periods
  function automatic logic [11:0] acr_win_len(input logic [2:0] code);
    case (code)
      3'h0:    acr_win_len = 12'h080;
      3'h1:    acr_win_len = 12'h100;
      3'h2:    acr_win_len = 12'h200;
      3'h3:    acr_win_len = 12'h300;
      3'h4:    acr_win_len = 12'h500;
      3'h5:    acr_win_len = 12'h700;
      3'h6:    acr_win_len = 12'hA00;
      default: acr_win_len = 12'hE00;
    endcase
  endfunction

  // exceedances needed: one shifted by the code
  function automatic logic [8:0] acr_need(input logic [2:0] code);
    acr_need = 9'h001 << code;
  endfunction
endpackage

// ### rtl/acr_det_if.sv
interface acr_det_if;
  logic        mode_on;
  logic [2:0]  len_code;
  logic [2:0]  num_code;
  logic        all_ch;
  logic [23:0] threshold;
  logic        detect_pulse;
  logic        window_pulse;
  modport ctrl (output mode_on, len_code, num_code, all_ch, threshold, input detect_pulse, window_pulse);
  modport eng  (input mode_on, len_code, num_code, all_ch, threshold, output detect_pulse, window_pulse);
endinterface

// ### rtl/acr_det_engine.sv
module acr_det_engine
  import acr_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  acr_det_if.eng                    det,
  input  wire logic                 sample_valid,
  input  wire logic [ACR_NCH*ACR_SW-1:0] sample_mag
);
  acr_det_state_t state, next_state;
  logic [11:0]    win_cnt, next_win_cnt;
  logic [8:0]     exc_cnt, next_exc_cnt;
  logic           next_det, next_win, det_q, win_q;
  logic [ACR_NCH-1:0] hit;
  logic           combined;
  logic [11:0]    len;
  logic [8:0]     need;

  // ==========================================================
  // threshold compare and channel combine
  always_comb begin
    for (int i = 0; i < ACR_NCH; i++) begin
      hit[i] = sample_mag[i*ACR_SW +: ACR_SW] > det.threshold;
    end
    combined = det.all_ch ? &hit : |hit;
    len      = acr_win_len(det.len_code);
    need     = acr_need(det.num_code);
  end

  // next state of window and exceedance counters
  always_comb begin
    next_state   = state;
    next_win_cnt = win_cnt;
    next_exc_cnt = exc_cnt;
    next_det     = 1'b0;
    next_win     = 1'b0;
    case (state)
      ACR_IDLE: begin
        next_win_cnt = 12'h000;
        next_exc_cnt = 9'h000;
        if (det.mode_on) begin
          next_state = ACR_RUN;
        end
      end
      ACR_RUN: begin
        if (!det.mode_on) begin
          next_state = ACR_IDLE;
        end else if (sample_valid) begin
          if (combined && exc_cnt < need) begin
            next_exc_cnt = exc_cnt + 9'h001;
            next_det     = (exc_cnt + 9'h001) == need;
          end
          if (win_cnt + 12'h001 == len) begin
            next_win     = 1'b1;
            next_win_cnt = 12'h000;
            next_exc_cnt = 9'h000;
          end else begin
            next_win_cnt = win_cnt + 12'h001;
          end
        end
      end
      default: next_state = ACR_IDLE;
    endcase
  end

  // register state
  always_ff @(posedge clk) begin
    if (srst) begin
      state   <= ACR_IDLE;
      win_cnt <= 12'h000;
      exc_cnt <= 9'h000;
      det_q   <= 1'b0;
      win_q   <= 1'b0;
    end else begin
      state   <= next_state;
      win_cnt <= next_win_cnt;
      exc_cnt <= next_exc_cnt;
      det_q   <= next_det;
      win_q   <= next_win;
    end
  end

  assign det.detect_pulse = det_q;
  assign det.window_pulse = win_q;

  // ==========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  property p_win_bound;
    state == ACR_RUN |-> win_cnt < len;
  endproperty
  a_win_bound: assert property (p_win_bound) else $error("window count past length");

  property p_det_count;
    $rose(det_q) |-> $past(exc_cnt) + 9'h001 == $past(need) && $past(combined);
  endproperty
  a_det_count: assert property (p_det_count) else $error("detect without required count");

  property p_all_ch;
    sample_valid && state == ACR_RUN && det.mode_on && det.all_ch && !(&hit) |=> exc_cnt <= $past(exc_cnt);
  endproperty
  a_all_ch: assert property (p_all_ch) else $error("count rose without all channels");

  property p_off_idle;
    !det.mode_on |=> state == ACR_IDLE ##1 !det_q;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("engine ran while disabled");

  c_detect: cover property (det_q);
  c_window: cover property (win_q);
endmodule

// ### rtl/acr_irq.sv
module acr_irq
  import acr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [1:0]  event_set,
  input  wire logic        clr_en,
  input  wire logic        mask_en,
  input  wire logic [15:0] wr_data,
  output logic      [1:0]  status,
  output logic      [1:0]  mask,
  output logic             irq
);
  logic [1:0] next_status, next_mask;

  // sticky status, write one to clear, set wins
  always_comb begin
    next_status = status;
    next_mask   = mask;
    if (clr_en) begin
      next_status = status & ~wr_data[1:0];
    end
    next_status = next_status | event_set;
    if (mask_en) begin
      next_mask = wr_data[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      status <= 2'b00;
      mask   <= 2'b00;
    end else begin
      status <= next_status;
      mask   <= next_mask;
    end
  end

  assign irq = |(status & mask);

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  property p_set_wins;
    event_set[IRQ_DETECT] |=> status[IRQ_DETECT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

  c_irq: cover property ($rose(irq));
endmodule

// ### rtl/acr_regs.sv
module acr_regs
  import acr_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic [ACR_AW-1:0]         addr,
  input  wire logic [ACR_DW-1:0]         wr_data,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  output logic      [ACR_DW-1:0]         rd_data,
  output logic                           irq,
  input  wire logic                      sample_valid,
  input  wire logic [ACR_NCH*ACR_SW-1:0] sample_mag,
  output logic      [9:0]                chan0_phase_delay,
  output logic                           chan0_dc_reject_off,
  output logic      [3:0]                dc_reject_setting,
  output logic      [3:0]                chan0_dc_filter,
  output logic      [1:0]                chan0_input_select,
  output logic      [23:0]               chan0_offset,
  output logic      [23:0]               chan0_gain
);
  // ==========================================================
  // register storage
  logic [15:0] cfg, next_cfg;
  logic [15:0] th_hi, next_th_hi;
  logic [15:0] th_lo, next_th_lo;
  logic [15:0] chan0_config, next_chan0_config;
  logic [15:0] ocal_hi, next_ocal_hi;
  logic [15:0] ocal_lo, next_ocal_lo;
  logic [15:0] gcal_hi, next_gcal_hi;
  logic [15:0] gcal_lo, next_gcal_lo;
  logic [15:0] next_rd_data;
  logic [3:0]  next_dc_filter;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;

  acr_det_if det ();

  // masked write into one register
  function automatic logic [15:0] reg_wr(input logic        hit,
                                         input logic [15:0] old,
                                         input logic [15:0] data,
                                         input logic [15:0] mask);
    reg_wr = hit ? (data & mask) : old;
  endfunction

  // ==========================================================
  // write decode
  always_comb begin
    next_cfg     = reg_wr(wr_en && addr == ADDR_CFG, cfg, wr_data, MASK_FULL);
    next_th_hi   = reg_wr(wr_en && addr == ADDR_TH_HI, th_hi, wr_data, MASK_FULL);
    next_th_lo   = reg_wr(wr_en && addr == ADDR_TH_LO, th_lo, wr_data, MASK_TH_LO);
    next_chan0_config = reg_wr(wr_en && addr == ADDR_CHAN0_CONFIG, chan0_config, wr_data, MASK_CH0);
    next_ocal_hi = reg_wr(wr_en && addr == ADDR_OCAL_HI, ocal_hi, wr_data, MASK_FULL);
    next_ocal_lo = reg_wr(wr_en && addr == ADDR_OCAL_LO, ocal_lo, wr_data, MASK_LOW_BYTE);
    next_gcal_hi = reg_wr(wr_en && addr == ADDR_GCAL_HI, gcal_hi, wr_data, MASK_FULL);
    next_gcal_lo = reg_wr(wr_en && addr == ADDR_GCAL_LO, gcal_lo, wr_data, MASK_LOW_BYTE);
  end

  // ==========================================================
  // read mux, data valid only the cycle after the strobe
  always_comb begin
    next_rd_data = RST_ZERO;
    if (rd_en) begin
      case (addr)
        ADDR_CFG:      next_rd_data = cfg;
        ADDR_TH_HI:    next_rd_data = th_hi;
        ADDR_TH_LO:    next_rd_data = th_lo;
        ADDR_CHAN0_CONFIG:  next_rd_data = chan0_config;
        ADDR_OCAL_HI:  next_rd_data = ocal_hi;
        ADDR_OCAL_LO:  next_rd_data = ocal_lo;
        ADDR_GCAL_HI:  next_rd_data = gcal_hi;
        ADDR_GCAL_LO:  next_rd_data = gcal_lo;
        ADDR_IRQ_STAT: next_rd_data = {14'h0000, irq_status};
        ADDR_IRQ_MASK: next_rd_data = {14'h0000, irq_mask};
        default:       next_rd_data = RST_ZERO;
      endcase
    end
  end

  // effective dc reject setting of channel 0
  always_comb begin
    next_dc_filter = chan0_config[CH0_DIS] ? DCB_OFF : th_lo[DCB_MSB:0];
  end

  // ==========================================================
  // register update
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg             <= RST_CFG;
      th_hi           <= RST_ZERO;
      th_lo           <= RST_ZERO;
      chan0_config         <= RST_ZERO;
      ocal_hi         <= RST_ZERO;
      ocal_lo         <= RST_ZERO;
      gcal_hi         <= RST_GCAL_HI;
      gcal_lo         <= RST_ZERO;
      rd_data         <= RST_ZERO;
      chan0_dc_filter <= DCB_OFF;
    end else begin
      cfg             <= next_cfg;
      th_hi           <= next_th_hi;
      th_lo           <= next_th_lo;
      chan0_config         <= next_chan0_config;
      ocal_hi         <= next_ocal_hi;
      ocal_lo         <= next_ocal_lo;
      gcal_hi         <= next_gcal_hi;
      gcal_lo         <= next_gcal_lo;
      rd_data         <= next_rd_data;
      chan0_dc_filter <= next_dc_filter;
    end
  end

  // ==========================================================
  // field outputs straight from registers
  assign chan0_phase_delay   = chan0_config[ACR_DW-1:CH0_PH_LSB];
  assign chan0_dc_reject_off = chan0_config[CH0_DIS];
  assign dc_reject_setting   = th_lo[DCB_MSB:0];
  assign chan0_input_select  = chan0_config[CH0_MUX_MSB:0];
  assign chan0_offset        = {ocal_hi, ocal_lo[ACR_DW-1:HI_BYTE_LSB]};
  assign chan0_gain          = {gcal_hi, gcal_lo[ACR_DW-1:HI_BYTE_LSB]};

  // detect engine configuration
  assign det.mode_on   = cfg[CFG_EN];
  assign det.len_code  = cfg[CFG_LEN_MSB:CFG_LEN_LSB];
  assign det.num_code  = cfg[CFG_NUM_MSB:CFG_NUM_LSB];
  assign det.all_ch    = cfg[CFG_ALL];
  assign det.threshold = {th_hi, th_lo[ACR_DW-1:HI_BYTE_LSB]};

  // ==========================================================
  // current detect engine and interrupt status
  acr_det_engine u_det (
    .clk          (clk),
    .srst         (srst),
    .det          (det.eng),
    .sample_valid (sample_valid),
    .sample_mag   (sample_mag)
  );

  acr_irq u_irq (
    .clk       (clk),
    .srst      (srst),
    .event_set ({det.window_pulse, det.detect_pulse}),
    .clr_en    (wr_en && addr == ADDR_IRQ_STAT),
    .mask_en   (wr_en && addr == ADDR_IRQ_MASK),
    .wr_data   (wr_data),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  // ==========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  property p_gain_reset;
    $fell(srst) |-> gcal_hi == RST_GCAL_HI && chan0_gain[ACR_SW-1] && !cfg[CFG_EN];
  endproperty
  a_gain_reset: assert property (p_gain_reset) else $error("reset value wrong");

  property p_ch0_readback;
    wr_en && addr == ADDR_CHAN0_CONFIG ##1 rd_en && addr == ADDR_CHAN0_CONFIG
      |=> rd_data == ($past(wr_data, 2) & MASK_CH0);
  endproperty
  a_ch0_readback: assert property (p_ch0_readback) else $error("channel config readback wrong");

  property p_th_lo_rsv;
    rd_en && addr == ADDR_TH_LO |=> rd_data[7:4] == 4'h0;
  endproperty
  a_th_lo_rsv: assert property (p_th_lo_rsv) else $error("threshold reserved bits set");

  property p_ch0_rsv;
    rd_en && addr == ADDR_CHAN0_CONFIG |=> rd_data[5:3] == 3'h0;
  endproperty
  a_ch0_rsv: assert property (p_ch0_rsv) else $error("channel reserved bits set");

  property p_ocal_lo;
    wr_en && addr == ADDR_OCAL_LO |=> chan0_offset[7:0] == $past(wr_data[15:8]) && ocal_lo[7:0] == 8'h00;
  endproperty
  a_ocal_lo: assert property (p_ocal_lo) else $error("offset low byte wrong");

  property p_gcal_lo;
    wr_en && addr == ADDR_GCAL_LO |=> chan0_gain[7:0] == $past(wr_data[15:8]) && gcal_lo[7:0] == 8'h00;
  endproperty
  a_gcal_lo: assert property (p_gcal_lo) else $error("gain low byte wrong");

  property p_dc_off;
    chan0_dc_reject_off |=> chan0_dc_filter == DCB_OFF;
  endproperty
  a_dc_off: assert property (p_dc_off) else $error("dc reject not off");

  property p_rd_idle;
    !rd_en |=> rd_data == RST_ZERO;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

  c_gain_write: cover property (wr_en && addr == ADDR_GCAL_HI ##1 rd_en && addr == ADDR_GCAL_HI);
endmodule

// ### tb/tb_adc_channel0_cfg_regs.sv
module tb_adc_channel0_cfg_regs
  import acr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus and observed signals
  logic        clk          = 1'b0;
  logic        srst         = 1'b1;
  logic [3:0]  addr         = 4'h0;
  logic [15:0] wr_data      = 16'h0000;
  logic        wr_en        = 1'b0;
  logic        rd_en        = 1'b0;
  logic        sample_valid = 1'b0;
  logic [95:0] sample_mag   = 96'h0;
  logic [15:0] rd_data;
  logic        irq;
  logic [9:0]  phase;
  logic        dc_off;
  logic [3:0]  dc_set;
  logic [3:0]  dc_filt;
  logic [1:0]  in_sel;
  logic [23:0] offs;
  logic [23:0] gain;
  int          err_total    = 0;
  int          num_checks   = 0;
  logic [31:0] seed         = 32'h2D7E60CE;
  logic [15:0] sh [16];
  logic [15:0] v;
  int          lens [8]     = '{128, 256, 512, 768, 1280, 1792, 2560, 3584};

  // free-running clock
  always #5 clk = ~clk;

  acr_regs i_dut (
    .clk                 (clk),
    .srst                (srst),
    .addr                (addr),
    .wr_data             (wr_data),
    .wr_en               (wr_en),
    .rd_en               (rd_en),
    .rd_data             (rd_data),
    .irq                 (irq),
    .sample_valid        (sample_valid),
    .sample_mag          (sample_mag),
    .chan0_phase_delay   (phase),
    .chan0_dc_reject_off (dc_off),
    .dc_reject_setting   (dc_set),
    .chan0_dc_filter     (dc_filt),
    .chan0_input_select  (in_sel),
    .chan0_offset        (offs),
    .chan0_gain          (gain)
  );

  // ==========================================================
  // expectation helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = x[0] ? ((x >> 1) ^ 32'hA3000000) : (x >> 1);
  endfunction

  // bits that a write may change
  function automatic logic [15:0] wmask(input int a);
    case (a)
      6, 7, 10, 12: wmask = 16'hFFFF;
      8:            wmask = 16'hFF0F;
      9:            wmask = 16'hFFC7;
      11, 13:       wmask = 16'hFF00;
      default:      wmask = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] rstv(input int a);
    case (a)
      6:       rstv = 16'h0600;
      12:      rstv = 16'h8000;
      default: rstv = 16'h0000;
    endcase
  endfunction

  // ==========================================================
  // bus, sample and report tasks
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
    wr_data <= ~d;
  endtask

  // read data sampled in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask

  // write then read the same place with no gap between strobes
  task automatic wrrd(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
    rd_en   <= 1'b1;
    @(posedge clk);
    rd_en   <= 1'b0;
    #1;
    v = rd_data;
  endtask

  task automatic samp(input logic [95:0] m);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_mag   <= m;
    @(posedge clk);
    sample_valid <= 1'b0;
    sample_mag   <= ~m;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // reset values, unmapped places included
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0]);
      chk("reset value", {8'h00, rstv(a)}, {8'h00, v});
    end
    chk("gain output", 24'h800000, gain);
    // random writes to places 0 to 13, reserved bits must stay zero
    for (int r = 0; r < 4; r++) begin
      for (int a = 0; a < 14; a++) begin
        seed = lfsr(seed);
        wr(a[3:0], seed[15:0]);
        sh[a] = seed[15:0] & wmask(a);
      end
      for (int a = 0; a < 14; a++) begin
        rd(a[3:0]);
        chk("readback", {8'h00, sh[a]}, {8'h00, v});
      end
      waitc(1);
      chk("phase", {14'h0, sh[9][15:6]}, {14'h0, phase});
      chk("dc off", {23'h0, sh[9][2]}, {23'h0, dc_off});
      chk("dc setting", {20'h0, sh[8][3:0]}, {20'h0, dc_set});
      chk("dc filter", {20'h0, sh[9][2] ? 4'h0 : sh[8][3:0]}, {20'h0, dc_filt});
      chk("input select", {22'h0, sh[9][1:0]}, {22'h0, in_sel});
      chk("offset", {sh[10], sh[11][15:8]}, offs);
      chk("gain", {sh[12], sh[13][15:8]}, gain);
    end
    // every input select code, dc reject toggled beside it
    for (int k = 0; k < 4; k++) begin
      wrrd(4'h9, {13'h0, k[0], k[1:0]});
      chk("ch0 readback", {21'h0, k[0], k[1:0]}, {8'h00, v});
      waitc(2);
      chk("input select code", {22'h0, k[1:0]}, {22'h0, in_sel});
      chk("dc filter", {20'h0, k[0] ? 4'h0 : sh[8][3:0]}, {20'h0, dc_filt});
    end
    seed = lfsr(seed);
    wrrd(4'hC, seed[15:0]);
    chk("gain readback", {8'h00, seed[15:0]}, {8'h00, v});
    // single detect: equal is not above, masked, then unmasked and cleared
    wr(4'h6, 16'h0000);
    wr(4'h7, 16'h0010);
    wr(4'h8, 16'h0000);
    wr(4'hF, 16'h0000);
    wr(4'hE, 16'h0003);
    wr(4'h6, 16'h0001);
    samp(96'h001000);
    waitc(3);
    rd(4'hE);
    chk("status at equal", 24'h0, {8'h00, v});
    samp(96'h001001);
    waitc(3);
    chk("irq masked", 24'h0, {23'h0, irq});
    rd(4'hE);
    chk("status detect", 24'h1, {8'h00, v});
    wr(4'hF, 16'h0001);
    waitc(1);
    chk("irq unmasked", 24'h1, {23'h0, irq});
    wr(4'hE, 16'h0001);
    waitc(1);
    chk("irq cleared", 24'h0, {23'h0, irq});
    // two exceedances needed
    wr(4'h6, 16'h0000);
    wr(4'hE, 16'h0003);
    wr(4'h6, 16'h0011);
    samp(96'h001001);
    waitc(3);
    chk("irq after one", 24'h0, {23'h0, irq});
    samp(96'h001001);
    waitc(3);
    chk("irq after two", 24'h1, {23'h0, irq});
    // all channels must exceed
    wr(4'h6, 16'h0000);
    wr(4'hE, 16'h0003);
    wr(4'h6, 16'h0081);
    samp(96'h001001);
    waitc(3);
    chk("irq one channel", 24'h0, {23'h0, irq});
    samp({4{24'h001001}});
    waitc(3);
    chk("irq all channels", 24'h1, {23'h0, irq});
    // every remaining exceedance count code
    for (int n = 2; n < 8; n++) begin
      wr(4'h6, 16'h0000);
      wr(4'hE, 16'h0003);
      wr(4'h6, {9'h000, n[2:0], 4'h1});
      repeat ((1 << n) - 1) samp(96'h001001);
      waitc(3);
      chk("irq below count", 24'h0, {23'h0, irq});
      samp(96'h001001);
      waitc(3);
      chk("irq at count", 24'h1, {23'h0, irq});
    end
    // window end after exactly the coded number of samples
    wr(4'hF, 16'h0002);
    for (int c = 0; c < 8; c++) begin
      wr(4'h6, 16'h0000);
      wr(4'hE, 16'h0003);
      wr(4'h6, {12'h000, c[2:0], 1'b1});
      repeat (lens[c] - 1) samp(96'h0);
      waitc(3);
      chk("window early", 24'h0, {23'h0, irq});
      samp(96'h0);
      waitc(3);
      chk("window end", 24'h1, {23'h0, irq});
    end
    conclude();
  end

  // hang guard, well beyond the expected run length
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule
